// ---- common/ucs_pkg.sv ----
// Constants for the serial configuration-high and status block.
// Assumes a 40 MHz system clock and an Avalon-MM slave with waitrequest.
//
// Function
// - Sleep-run set keeps the baud clock running in sleep, clear stops it.
// - Clock-request status reads one while active; config writes then ignored.
// - Fractional select picks fractional baud; else legacy divide by 4 or 16.
// - Baud source 10 is full oscillator, 00 half; 01 and 11 reserved.
// - Half duplex drives transmit pin only while sending; full duplex while unit and transmit enabled.
// - Overflow with run-on set keeps shifter synced, no overwrite; else stops.
// - Receive invert set inverts the input so it idles low.
// - Stop field: 00 one, 01 one and half, 10 two, 11 send two check one.
// - Checksum kind picks enhanced LIN or word sum; clear picks legacy or none.
// - Transmit invert set inverts the output so the line idles low.
// - Handshake field acts only in basic async codes; 10 hw, 01 xon, 00 off.
// - Eight enable bits gate their conditions onto the interrupt request.
// - Shifter-empty flag resets to one and reads one when shifter empties.
// - Parity/address flag shows parity error or address receipt by mode.
// - Auto-baud rollover sets a sticky flag software must clear.
// - Checksum mismatch sets a sticky flag software must clear.
// - Framing flag is the inverted stop bit of the topmost buffered character.
// - Break received sets a flag held until software clears it.
// - Receive buffer overflow sets a sticky flag software must clear.
// - Transmit/receive word mismatch sets a collision flag software clears.
// - Protocol codes: 0100 address, 0011 even, 0010 odd, 1011/1100 LIN.
// - Stop timing set places receive event at last stop end, else middle.
package ucs_pkg;
   localparam logic [1:0] ADDR_CONFIG_HIGH = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_STOP_TIMING = 2'h2;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam int BIT_SLEEP_RUN = 15;
   localparam int BIT_ACTIVE = 14;
   localparam int BIT_FRAC = 11;
   localparam int BIT_HALF_DUPLEX = 8;
   localparam int BIT_RUN_OVF = 7;
   localparam int BIT_RX_INV = 6;
   localparam int BIT_CHECKSUM = 3;
   localparam int BIT_TX_INV = 2;
   localparam logic [15:0] CONFIG_WR_MASK = 16'h8fff;
   localparam logic [1:0] SRC_FULL = 2'h2;
   localparam logic [1:0] SRC_HALF = 2'h0;
   localparam logic [3:0] PROTO_ADDR = 4'h4;
   localparam logic [3:0] PROTO_EVEN = 4'h3;
   localparam logic [3:0] PROTO_ODD = 4'h2;
   localparam logic [3:0] PROTO_LIN_SLAVE = 4'hb;
   localparam logic [3:0] PROTO_LIN_MASTER = 4'hc;
   localparam logic [1:0] FLOW_OFF = 2'h0;
   localparam logic [1:0] FLOW_XON = 2'h1;
   localparam logic [1:0] FLOW_HW = 2'h2;
   localparam logic [1:0] STOP_ONE = 2'h0;
   localparam logic [1:0] STOP_ONE_HALF = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [1:0] STOP_TWO_ONE = 2'h3;
   localparam logic [4:0] LEGACY_DIV_FAST = 5'h04;
   localparam logic [4:0] LEGACY_DIV_SLOW = 5'h10;
   typedef enum logic [1:0]
   {
      UCS_BUS_IDLE = 2'b00,
      UCS_BUS_ACK = 2'b01
   } ucs_bus_t;
endpackage : ucs_pkg

// ---- rtl/ucs_top.sv ----
// Configuration-high and status register block of a serial transceiver.
// Assumes the shifters and buffers elsewhere report events as one-cycle
// pulses and levels; the mode code and enables arrive as plain inputs.
`timescale 1ns/10ps
module ucs_top
   import ucs_pkg::*;
(
   input wire logic clock,                // 40 MHz system clock
   input wire logic resetn,               // Asynchronous reset, active low
   input wire logic [1:0] avs_address,    // Word address
   input wire logic avs_read,             // Read request
   input wire logic avs_write,            // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata,      // Read data
   output logic avs_waitrequest,          // Stall until answer
   input wire logic [3:0] protocol_select, // Mode code
   input wire logic module_enable,        // Unit enable
   input wire logic transmit_enable,      // Transmit enable
   input wire logic high_speed_baud,      // Legacy divide by 4
   input wire logic sleep_mode,           // Device in sleep
   input wire logic osc_tick,             // Oscillator clock enable pulse
   input wire logic clock_request,        // Unit clock request
   input wire logic tx_busy,              // Frame being sent
   input wire logic tx_serial,            // Shifter output, true polarity
   input wire logic rx_pin,               // Receive pin level
   input wire logic shifter_done_end,     // Shifter empty at last stop end
   input wire logic shifter_done_mid,     // Shifter empty mid first stop
   input wire logic shifter_load,         // Shifter loaded with a word
   input wire logic parity_err_evt,       // Parity error seen
   input wire logic address_evt,          // Address word seen
   input wire logic autobaud_roll_evt,    // Divider rolled during auto-baud
   input wire logic checksum_err_evt,     // Checksum mismatch
   input wire logic top_stop_bit,         // Stop bit of topmost buffered word
   input wire logic break_evt,            // Break received
   input wire logic rx_word_evt,          // Word complete at shifter
   input wire logic rx_buffer_full,       // Receive buffer full
   input wire logic tx_echo_mismatch,     // Sent word differs from echo
   output logic rx_data_in,               // Receive line, polarity fixed
   output logic transmit_pin_out,         // Transmit pin level
   output logic transmit_pin_oe_n,        // Transmit pin enable, low drives
   output logic baud_tick,                // Baud clock enable pulse
   output logic rx_store,                 // Move shifter word to buffer
   output logic rx_shift_run,             // Receive shifter may run
   output logic frac_baud,                // Fractional generation on
   output logic [4:0] legacy_div,         // Legacy divide ratio
   output logic [1:0] stop_tx_sel,        // Stop bits to send
   output logic [1:0] stop_rx_sel,        // Stop bits to check
   output logic [1:0] checksum_mode,      // 0 none,1 legacy LIN,2 enh,3 sum
   output logic [1:0] flow_mode,          // Effective handshake mode
   output logic stop_at_end,              // Receive event at last stop end
   output logic irq_request               // Enabled condition pending
);

   //------------------------------------------------------------------
   // Registers
   //------------------------------------------------------------------
   logic [15:0] config_reg;
   logic [7:0] enable_reg;
   logic stop_timing_reg;
   logic shifter_empty_reg;
   logic parity_reg;
   logic autobaud_reg;
   logic checksum_reg;
   logic break_reg;
   logic overflow_reg;
   logic collision_reg;
   logic overflow_hold_reg;
   logic half_div_reg;
   ucs_bus_t bus_reg;
   logic [7:0] status_low;
   logic wr_lo;
   logic wr_hi;
   logic wr_status;
   logic is_lin;
   logic is_parity;
   logic overflow_evt;
   logic src_tick;

   assign is_lin = (protocol_select == PROTO_LIN_SLAVE) ||
                   (protocol_select == PROTO_LIN_MASTER);
   assign is_parity = (protocol_select == PROTO_EVEN) ||
                      (protocol_select == PROTO_ODD);
   assign wr_status = (bus_reg == UCS_BUS_IDLE) && avs_write &&
                      (avs_address == ADDR_STATUS);
   // Config writes are ignored while the unit requests its clock
   assign wr_lo = (bus_reg == UCS_BUS_IDLE) && avs_write &&
                  (avs_address == ADDR_CONFIG_HIGH) &&
                  avs_byteenable[0] && !clock_request;
   assign wr_hi = (bus_reg == UCS_BUS_IDLE) && avs_write &&
                  (avs_address == ADDR_CONFIG_HIGH) &&
                  avs_byteenable[1] && !clock_request;
   assign overflow_evt = rx_word_evt && rx_buffer_full;
   assign status_low = {shifter_empty_reg, parity_reg, autobaud_reg,
                        checksum_reg, !top_stop_bit, break_reg,
                        overflow_reg, collision_reg};

   //------------------------------------------------------------------
   // Bus slave: one wait cycle, answer on the second
   //------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         bus_reg <= UCS_BUS_IDLE;
      else
         case (bus_reg)
            UCS_BUS_IDLE: if (avs_read || avs_write) bus_reg <= UCS_BUS_ACK;
            UCS_BUS_ACK: bus_reg <= UCS_BUS_IDLE;
            default: bus_reg <= UCS_BUS_IDLE;
         endcase

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((bus_reg == UCS_BUS_IDLE) &&
                              (avs_read || avs_write));

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         avs_readdata <= 32'h0;
      else if (bus_reg == UCS_BUS_IDLE && avs_read)
         case (avs_address)
            ADDR_CONFIG_HIGH:
               avs_readdata <= {16'h0, config_reg[15], clock_request,
                                config_reg[13:0]};
            ADDR_STATUS: avs_readdata <= {16'h0, enable_reg, status_low};
            ADDR_STOP_TIMING: avs_readdata <= {31'h0, stop_timing_reg};
            default: avs_readdata <= 32'h0;
         endcase

   //------------------------------------------------------------------
   // Configuration and enables
   //------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         config_reg <= CONFIG_RESET;
      else
      begin
         if (wr_lo)
            config_reg[7:0] <= avs_writedata[7:0];
         if (wr_hi)
            config_reg[15:8] <= avs_writedata[15:8] & CONFIG_WR_MASK[15:8];
      end

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         enable_reg <= ENABLE_RESET;
      else if (wr_status && avs_byteenable[1])
         enable_reg <= avs_writedata[15:8];

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         stop_timing_reg <= 1'b0;
      else if ((bus_reg == UCS_BUS_IDLE) && avs_write &&
               (avs_address == ADDR_STOP_TIMING) && avs_byteenable[0])
         stop_timing_reg <= avs_writedata[0];

   //------------------------------------------------------------------
   // Sticky flags: set wins over a written zero, ones ignored
   //------------------------------------------------------------------
   function automatic logic sticky(input logic cur, input logic evt,
                                   input logic wbit, input logic wen);
      sticky = evt || (cur && !(wen && !wbit));
   endfunction : sticky

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         autobaud_reg <= 1'b0;
         checksum_reg <= 1'b0;
         break_reg <= 1'b0;
         overflow_reg <= 1'b0;
         collision_reg <= 1'b0;
      end
      else
      begin
         autobaud_reg <= sticky(autobaud_reg, autobaud_roll_evt,
                                avs_writedata[5],
                                wr_status && avs_byteenable[0]);
         checksum_reg <= sticky(checksum_reg, checksum_err_evt,
                                avs_writedata[4],
                                wr_status && avs_byteenable[0]);
         break_reg <= sticky(break_reg, break_evt, avs_writedata[2],
                             wr_status && avs_byteenable[0]);
         overflow_reg <= sticky(overflow_reg, overflow_evt,
                                avs_writedata[1],
                                wr_status && avs_byteenable[0]);
         collision_reg <= sticky(collision_reg, tx_echo_mismatch,
                                 avs_writedata[0],
                                 wr_status && avs_byteenable[0]);
      end

   // Parity or address status, meaningful only in those modes
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         parity_reg <= 1'b0;
      else if (is_lin || is_parity)
         parity_reg <= sticky(parity_reg, parity_err_evt, avs_writedata[6],
                              wr_status && avs_byteenable[0]);
      else if (protocol_select == PROTO_ADDR)
         parity_reg <= sticky(parity_reg, address_evt, avs_writedata[6],
                              wr_status && avs_byteenable[0]);
      else
         parity_reg <= 1'b0;

   // Shifter empty: load clears, end event per stop timing sets
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         shifter_empty_reg <= 1'b1;
      else if (shifter_load)
         shifter_empty_reg <= 1'b0;
      else if (stop_timing_reg ? shifter_done_end : shifter_done_mid)
         shifter_empty_reg <= 1'b1;

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         irq_request <= 1'b0;
      else
         irq_request <= |(enable_reg & status_low);

   //------------------------------------------------------------------
   // Receive overflow handling
   //------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         overflow_hold_reg <= 1'b0;
      else if (overflow_evt && !config_reg[BIT_RUN_OVF])
         overflow_hold_reg <= 1'b1;
      else if (!overflow_reg)
         overflow_hold_reg <= 1'b0;

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         rx_store <= 1'b0;
         rx_shift_run <= 1'b1;
      end
      else
      begin
         rx_store <= rx_word_evt && !rx_buffer_full;
         rx_shift_run <= !overflow_hold_reg && !(overflow_evt &&
                         !config_reg[BIT_RUN_OVF]);
      end

   //------------------------------------------------------------------
   // Baud clock source and sleep gating
   //------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         half_div_reg <= 1'b0;
      else if (osc_tick)
         half_div_reg <= !half_div_reg;

   assign src_tick = (config_reg[10:9] == SRC_FULL) ? osc_tick :
                     (config_reg[10:9] == SRC_HALF) ?
                     (osc_tick && half_div_reg) : 1'b0;

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
         baud_tick <= 1'b0;
      else
         baud_tick <= src_tick && (!sleep_mode ||
                                   config_reg[BIT_SLEEP_RUN]);

   //------------------------------------------------------------------
   // Line polarity, pin drive and mode decode
   //------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         rx_data_in <= 1'b1;
         transmit_pin_out <= 1'b1;
         transmit_pin_oe_n <= 1'b1;
      end
      else
      begin
         rx_data_in <= rx_pin ^ config_reg[BIT_RX_INV];
         transmit_pin_out <= tx_serial ^ config_reg[BIT_TX_INV];
         transmit_pin_oe_n <= config_reg[BIT_HALF_DUPLEX] ? !tx_busy :
                              !(module_enable && transmit_enable);
      end

   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         frac_baud <= 1'b0;
         legacy_div <= LEGACY_DIV_SLOW;
         stop_tx_sel <= STOP_ONE;
         stop_rx_sel <= STOP_ONE;
         checksum_mode <= 2'h0;
         flow_mode <= FLOW_OFF;
         stop_at_end <= 1'b0;
      end
      else
      begin
         frac_baud <= config_reg[BIT_FRAC];
         legacy_div <= high_speed_baud ? LEGACY_DIV_FAST :
                       LEGACY_DIV_SLOW;
         stop_tx_sel <= (config_reg[5:4] == STOP_TWO_ONE) ? STOP_TWO :
                        config_reg[5:4];
         stop_rx_sel <= (config_reg[5:4] == STOP_TWO_ONE) ? STOP_ONE :
                        config_reg[5:4];
         checksum_mode <= is_lin ? {config_reg[BIT_CHECKSUM],
                                    !config_reg[BIT_CHECKSUM]} :
                          {2{config_reg[BIT_CHECKSUM]}};
         flow_mode <= (!protocol_select[3] &&
                       (config_reg[1:0] == FLOW_HW ||
                        config_reg[1:0] == FLOW_XON)) ?
                      config_reg[1:0] : FLOW_OFF;
         stop_at_end <= stop_timing_reg;
      end

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   sticky_hold_a: assert property (@(posedge clock) disable iff (!resetn)
      break_reg && !(wr_status && avs_byteenable[0]) |=> break_reg)
      else $error("break flag dropped without a clear");
   set_wins_a: assert property (@(posedge clock) disable iff (!resetn)
      collision_reg == 1'b0 && tx_echo_mismatch |=> collision_reg)
      else $error("collision event lost");
   ovf_set_a: assert property (@(posedge clock) disable iff (!resetn)
      rx_word_evt && rx_buffer_full |=> overflow_reg)
      else $error("overflow not flagged");
   no_store_a: assert property (@(posedge clock) disable iff (!resetn)
      rx_word_evt && rx_buffer_full |=> !rx_store)
      else $error("full buffer overwritten");
   cfg_lock_a: assert property (@(posedge clock) disable iff (!resetn)
      clock_request |=> $stable(config_reg))
      else $error("config changed while active");
   sleep_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      sleep_mode && !config_reg[BIT_SLEEP_RUN] |=> !baud_tick)
      else $error("baud tick in sleep");
   full_duplex_a: assert property (@(posedge clock) disable iff (!resetn)
      !config_reg[BIT_HALF_DUPLEX] && module_enable && transmit_enable
      |=> !transmit_pin_oe_n)
      else $error("pin not driven in full duplex");
   rx_invert_a: assert property (@(posedge clock) disable iff (!resetn)
      1'b1 |=> rx_data_in == ($past(rx_pin) ^ $past(config_reg[BIT_RX_INV])))
      else $error("receive polarity wrong");
   irq_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      enable_reg == 8'h00 |=> !irq_request)
      else $error("interrupt raised while masked");
   stop_map_a: assert property (@(posedge clock) disable iff (!resetn)
      config_reg[5:4] == STOP_TWO_ONE |=>
      stop_tx_sel == STOP_TWO && stop_rx_sel == STOP_ONE)
      else $error("stop field decode wrong");

endmodule : ucs_top

// ---- verification/ucs_station.sv ----
// Remote serial station facing the transmit and receive pins.
// Assumes a pull-up on the transmit wire and an echo of it on receive.
`timescale 1ns/10ps
module ucs_station
(
   input wire logic clock,      // System clock
   input wire logic pin_level,  // Transmit pin level from the block
   input wire logic pin_oe_n,   // Transmit pin enable, low drives
   input wire logic send_break, // Hold the receive line low
   output logic rx_line,        // Level offered to the receive pin
   output logic line_level      // Resolved transmit wire level
);
   // Released wire floats to the pull-up level
   assign line_level = pin_oe_n ? 1'b1 : pin_level;
   // Shared line echoes back; a break holds it low
   always_ff @(posedge clock)
   begin
      rx_line <= send_break ? 1'b0 : line_level;
   end
endmodule : ucs_station

// ---- verification/uart_config_high_and_status_test.sv ----
// Self-checking bench for the configuration-high and status block.
// Assumes the package and the remote station model are compiled first.
`timescale 1ns/10ps
module uart_config_high_and_status_test
   import ucs_pkg::*;
;
   logic clock = 1'b0;
   logic resetn, avs_read, avs_write, module_enable, transmit_enable;
   logic high_speed_baud, sleep_mode, osc_tick, clock_request, tx_busy;
   logic tx_serial, shifter_done_end, shifter_done_mid, shifter_load;
   logic parity_err_evt, address_evt, autobaud_roll_evt, checksum_err_evt;
   logic top_stop_bit, break_evt, rx_word_evt, rx_buffer_full, rx_pin;
   logic tx_echo_mismatch, send_break, line_level, avs_waitrequest;
   logic rx_data_in, transmit_pin_out, transmit_pin_oe_n, baud_tick;
   logic rx_store, rx_shift_run, frac_baud, stop_at_end, irq_request;
   logic [1:0] avs_address, stop_tx_sel, stop_rx_sel, checksum_mode;
   logic [1:0] flow_mode;
   logic [3:0] avs_byteenable, protocol_select;
   logic [4:0] legacy_div;
   logic [31:0] avs_writedata, avs_readdata, q;
   int err_count = 0;
   int cmp_count = 0;
   int i, n;
   always #12.5 clock = ~clock;
   ucs_top uut
   (
      .clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .protocol_select,
      .module_enable, .transmit_enable, .high_speed_baud, .sleep_mode,
      .osc_tick, .clock_request, .tx_busy, .tx_serial, .rx_pin,
      .shifter_done_end, .shifter_done_mid, .shifter_load, .parity_err_evt,
      .address_evt, .autobaud_roll_evt, .checksum_err_evt, .top_stop_bit,
      .break_evt, .rx_word_evt, .rx_buffer_full, .tx_echo_mismatch,
      .rx_data_in, .transmit_pin_out, .transmit_pin_oe_n, .baud_tick,
      .rx_store, .rx_shift_run, .frac_baud, .legacy_div, .stop_tx_sel,
      .stop_rx_sel, .checksum_mode, .flow_mode, .stop_at_end, .irq_request
   );
   ucs_station station
   (
      .clock, .pin_level(transmit_pin_out), .pin_oe_n(transmit_pin_oe_n),
      .send_break, .rx_line(rx_pin), .line_level
   );
   // ------------------------------------------------------------
   // Bus access and checking
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [1:0] a, input logic w,
                      input logic [15:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      do
         @(posedge clock);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      bus(a, 1'b0, 16'h0000);
      chk(q, {16'h0000, e});
   endtask : rd
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask : settle
   task automatic ticks(output int c);
      c = 0;
      repeat (32)
      begin
         @(posedge clock);
         c += int'(baud_tick === 1'b1);
      end
   endtask : ticks
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      {avs_read, avs_write, avs_address, avs_writedata, protocol_select} = '0;
      {module_enable, transmit_enable, high_speed_baud, sleep_mode} = '0;
      {osc_tick, clock_request, tx_busy, shifter_done_end} = '0;
      {shifter_done_mid, shifter_load, parity_err_evt, address_evt} = '0;
      {autobaud_roll_evt, checksum_err_evt, break_evt, rx_word_evt} = '0;
      {rx_buffer_full, tx_echo_mismatch, send_break, resetn} = '0;
      {tx_serial, top_stop_bit, avs_byteenable} = 6'h3f;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      rd(ADDR_STATUS, 16'h0080);
      wr(ADDR_CONFIG_HIGH, 16'hffff);
      rd(ADDR_CONFIG_HIGH, 16'h8fff);
      settle();
      chk({stop_tx_sel, stop_rx_sel, flow_mode}, 6'h20);
      chk({checksum_mode, frac_baud}, 3'h7);
      chk({transmit_pin_oe_n, transmit_pin_out, rx_data_in}, 3'h4);
      @(posedge clock);
      {clock_request, tx_busy, send_break} <= 3'h7;
      settle();
      chk({transmit_pin_oe_n, rx_data_in}, 2'h1);
      wr(ADDR_CONFIG_HIGH, 16'h0000);
      rd(ADDR_CONFIG_HIGH, 16'hcfff);
      {clock_request, tx_busy, send_break} <= 3'h0;
      {module_enable, transmit_enable} <= 2'h3;
      for (i = 0; i < 4; i++)
      begin
         wr(ADDR_CONFIG_HIGH, 16'(i * 17));
         high_speed_baud <= i[0];
         settle();
         chk(stop_tx_sel, (i == 3) ? STOP_TWO : 2'(i));
         chk(stop_rx_sel, (i == 3) ? STOP_ONE : 2'(i));
         chk(flow_mode, (i == 3) ? FLOW_OFF : 2'(i));
         chk(legacy_div, i[0] ? LEGACY_DIV_FAST : LEGACY_DIV_SLOW);
         chk({transmit_pin_oe_n, rx_data_in}, 2'h1);
      end
      wr(ADDR_CONFIG_HIGH, 16'h0400);
      {osc_tick, sleep_mode} <= 2'h3;
      ticks(n);
      chk(n, 0);
      wr(ADDR_CONFIG_HIGH, 16'h8400);
      ticks(n);
      chk(n, 32);
      wr(ADDR_CONFIG_HIGH, 16'h8000);
      ticks(n);
      chk(n, 16);
      wr(ADDR_CONFIG_HIGH, 16'h8200);
      ticks(n);
      chk(n, 0);
      wr(ADDR_CONFIG_HIGH, 16'h000a);
      {osc_tick, sleep_mode} <= 2'h0;
      protocol_select <= PROTO_LIN_SLAVE;
      settle();
      chk({checksum_mode, flow_mode}, 4'h8);
      @(posedge clock);
      protocol_select <= PROTO_EVEN;
      {top_stop_bit, rx_buffer_full} <= 2'h1;
      {parity_err_evt, autobaud_roll_evt, checksum_err_evt, break_evt} <= '1;
      {rx_word_evt, tx_echo_mismatch, shifter_load} <= '1;
      @(posedge clock);
      {parity_err_evt, autobaud_roll_evt, checksum_err_evt, break_evt} <= '0;
      {rx_word_evt, tx_echo_mismatch, shifter_load} <= '0;
      settle();
      chk({checksum_mode, flow_mode, rx_shift_run}, 5'h1c);
      rd(ADDR_STATUS, 16'h007f);
      wr(ADDR_STATUS, 16'h00ff);
      rd(ADDR_STATUS, 16'h007f);
      chk(irq_request, 1'b0);
      protocol_select <= 4'h0;
      wr(ADDR_STATUS, 16'h0800);
      rd(ADDR_STATUS, 16'h0808);
      chk({irq_request, rx_shift_run}, 2'h3);
      wr(ADDR_STATUS, 16'h0000);
      settle();
      chk(irq_request, 1'b0);
      @(posedge clock);
      protocol_select <= PROTO_ADDR;
      address_evt <= 1'b1;
      @(posedge clock);
      address_evt <= 1'b0;
      rd(ADDR_STATUS, 16'h0048);
      protocol_select <= 4'h0;
      wr(ADDR_STOP_TIMING, 16'h0001);
      shifter_done_mid <= 1'b1;
      @(posedge clock);
      shifter_done_mid <= 1'b0;
      rd(ADDR_STATUS, 16'h0008);
      chk(stop_at_end, 1'b1);
      shifter_done_end <= 1'b1;
      @(posedge clock);
      shifter_done_end <= 1'b0;
      rd(ADDR_STATUS, 16'h0088);
      wr(ADDR_CONFIG_HIGH, 16'h0080);
      {rx_word_evt, rx_buffer_full} <= 2'h3;
      @(posedge clock);
      rx_buffer_full <= 1'b0;
      #1;
      chk({rx_store, rx_shift_run}, 2'h1);
      @(posedge clock);
      rx_word_evt <= 1'b0;
      #1;
      chk({rx_store, rx_shift_run}, 2'h3);
      wr(2'h3, 16'hffff);
      rd(2'h3, 16'h0000);
      print_verdict();
   end
   initial
   begin
      repeat (4000) @(posedge clock);
      err_count++;
      print_verdict();
   end
endmodule : uart_config_high_and_status_test
